// >>> inc/gi_pkg.sv
// constants for the gamma interpolator and row dimming block
package gi_pkg;

	localparam int GI_NPTS = 8;
	localparam int GI_NCH = 3;
	localparam int GI_IN_W = 8;
	localparam int GI_OUT_W = 10;
	localparam int GI_ADDR_W = 5;
	localparam int GI_DATA_W = 16;

	// fixed grayscale coordinates of the anchor points
	localparam logic [7:0] GI_GL [GI_NPTS] = '{8'h02, 8'h04, 8'h08, 8'h10,
		8'h20, 8'h40, 8'h80, 8'hff};

	// register offsets
	localparam logic [4:0] GI_A_COEF0 = 5'h00;
	localparam logic [4:0] GI_A_BLACK = 5'h08;
	localparam logic [4:0] GI_A_UPDATE = 5'h09;
	localparam logic [4:0] GI_A_PTSEL = 5'h0a;
	localparam logic [4:0] GI_A_DIM = 5'h0b;
	localparam logic [4:0] GI_A_MAXCUR = 5'h0c;
	localparam logic [4:0] GI_A_CATHODE = 5'h0d;
	localparam logic [4:0] GI_A_ROWBLANK = 5'h0e;
	localparam logic [4:0] GI_A_DISPCTL = 5'h0f;
	localparam logic [4:0] GI_A_FRAMELEN = 5'h10;

	// field positions
	localparam int GI_UPD_GO_BIT = 3;
	localparam int GI_FINE_W = 4;
	localparam int GI_COARSE_LSB = 4;
	localparam int GI_COARSE_W = 4;
	localparam int GI_DIM_W = 7;
	localparam int GI_CATH_W = 4;
	localparam int GI_ROWBLANK_W = 13;

	// reset values, then the full dim level and the highest cathode mode in which dimming acts
	localparam logic [9:0] GI_COEF_RST = 10'h000;
	localparam logic [9:0] GI_BLACK_RST = 10'h001;
	localparam logic [6:0] GI_DIM_RST = 7'h7f;
	localparam logic [7:0] GI_MAXCUR_RST = 8'h00;
	localparam logic [3:0] GI_CATH_RST = 4'h0;
	localparam logic [12:0] GI_ROWBLANK_RST = 13'h0000;
	localparam logic GI_DISPBLANK_RST = 1'b1;
	localparam logic [6:0] GI_DIM_FULL = 7'h7f;
	localparam logic [3:0] GI_CATH_DIM_MAX = 4'h1;

endpackage : gi_pkg

// >>> inc/gi_chan_if.sv
// carrier between the top and one colour channel interpolator
`timescale 1ns/1ps
interface gi_chan_if;
	import gi_pkg::*;
	logic [GI_IN_W-1:0] pix;
	logic blank;
	logic [GI_OUT_W-1:0] coef [GI_NPTS];
	logic [GI_OUT_W-1:0] q0;
	logic [GI_OUT_W-1:0] res;

	modport host (output pix, output blank, output coef, output q0, input res);
	modport core (input pix, input blank, input coef, input q0, output res);
endinterface : gi_chan_if

// >>> logic/gi_interp.sv
// piecewise-linear gamma interpolator for one colour channel
`timescale 1ns/1ps
module gi_interp (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	gi_chan_if.core ch
);
	import gi_pkg::*;

	function automatic logic [9:0] gi_clamp(input logic signed [20:0] v);
		if (v < 21'sd0)
			return 10'h000;
		else if (v > 21'sd1023)
			return 10'h3ff;
		else
			return v[9:0];
	endfunction : gi_clamp

	logic [2:0] seg;
	logic signed [8:0] off;
	logic signed [10:0] diff;
	logic signed [8:0] span;
	logic signed [20:0] prod;
	logic signed [20:0] val;
	logic [9:0] res_nxt;

	//////////////////////////////////////////////////////////////////////
	// segment search and interpolation
	always_comb begin
		seg = 3'd0;
		for (int k = 1; k < GI_NPTS - 1; k++) begin
			if (ch.pix >= GI_GL[k]) begin
				seg = 3'(k);
			end
		end
		// levels 1..3 fall in segment 0; level 1 has a negative offset: extrapolation
		off = $signed({1'b0, ch.pix}) - $signed({1'b0, GI_GL[seg]});
		diff = $signed({1'b0, ch.coef[seg + 3'd1]}) - $signed({1'b0, ch.coef[seg]});
		span = $signed({1'b0, GI_GL[seg + 3'd1]}) - $signed({1'b0, GI_GL[seg]});
		prod = 21'(off * diff);
		val = $signed({11'h000, ch.coef[seg]}) + prod / 21'(span);
		if (ch.blank)
			res_nxt = 10'h000;
		else if (ch.pix == 8'h00)
			res_nxt = gi_clamp($signed({11'h000, ch.q0}));
		else
			res_nxt = gi_clamp(val);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ch.res <= 10'h000;
		end else begin
			ch.res <= res_nxt;
		end
	end

endmodule : gi_interp

// >>> logic/gi_gamma_dim.sv
// gamma interpolation, analog dimming controls and row-reset duty generator
// Functional notes
// - each 8-bit colour component becomes a 10-bit gamma-corrected code
// - output is interpolated in real time between bracketing anchor points
// - anchor inputs fixed at 2,4,8,16,32,64,128,255; only outputs programmable
// - host writes point select 0..7; block presents chosen point to sense output
// - eight coefficient registers hold 10 usable bits each
// - low three bits of update control select the targeted colour channels
// - writing one to update bit 3 copies coefficients into selected channels
// - gray level zero outputs a user-set fixed black level value
// - gray levels 1 to 3 extrapolate linearly from first two anchors
// - 7-bit dim level gives 128 linear steps up to maximum reference
// - dim level acts only while cathode mode is 0 or 1
// - maximum current reference has a coarse field and a fine trim field
// - 13-bit row blank count; zero means never blank, full duty
// - row reset pulse rises 2*W line cycles before the row's next programming
// - a row reset pulse blacks its row until reprogrammed next frame
// - row N programmed at line N after init lines; same duty all rows
// - array stays black after reset until host clears the blank bit
`timescale 1ns/1ps
module gi_gamma_dim #(
	parameter int INIT_LINES = 2,
	parameter int NUM_ROWS = 2072,
	parameter int LINE_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [gi_pkg::GI_ADDR_W-1:0] i_reg_addr,
	input wire logic [gi_pkg::GI_DATA_W-1:0] i_reg_wdata,
	output logic [gi_pkg::GI_DATA_W-1:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// video in
	input wire logic i_pix_valid,
	input wire logic [gi_pkg::GI_IN_W-1:0] i_pix_r,
	input wire logic [gi_pkg::GI_IN_W-1:0] i_pix_g,
	input wire logic [gi_pkg::GI_IN_W-1:0] i_pix_b,
	input wire logic i_hsync,
	input wire logic i_vsync,
	// video out
	output logic o_pix_valid,
	output logic [gi_pkg::GI_OUT_W-1:0] o_pix_r,
	output logic [gi_pkg::GI_OUT_W-1:0] o_pix_g,
	output logic [gi_pkg::GI_OUT_W-1:0] o_pix_b,
	// analog controls
	output logic [2:0] o_gamma_point_select,
	output logic [gi_pkg::GI_DIM_W-1:0] o_dim_level,
	output logic [gi_pkg::GI_COARSE_W-1:0] o_max_current_coarse,
	output logic [gi_pkg::GI_FINE_W-1:0] o_max_current_fine,
	output logic [gi_pkg::GI_CATH_W-1:0] o_cathode_mode,
	output logic o_display_blank,
	// row reset
	output logic o_row_reset_pulse,
	output logic [LINE_W-1:0] o_row_reset_row
);
	import gi_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// helpers

	// offsets 0..7 address the staged coefficient set
	function automatic logic gi_is_coef(input logic [GI_ADDR_W-1:0] a);
		return a < GI_A_BLACK;
	endfunction : gi_is_coef

	logic [GI_OUT_W-1:0] coef_stage_r [GI_NPTS];
	logic [GI_OUT_W-1:0] bank_r [GI_NCH][GI_NPTS];
	logic [GI_OUT_W-1:0] black_stage_r;
	logic [GI_OUT_W-1:0] black_r [GI_NCH];
	logic [2:0] chan_sel_r;
	logic [2:0] point_sel_r;
	logic [GI_DIM_W-1:0] dim_r;
	logic [7:0] maxcur_r;
	logic [GI_CATH_W-1:0] cath_r;
	logic [GI_ROWBLANK_W-1:0] row_blank_r;
	logic disp_blank_r;
	logic [LINE_W-1:0] line_r;
	logic [LINE_W-1:0] frame_len_r;
	logic pix_valid_r;
	logic upd_go;
	logic [LINE_W+1:0] tgt_raw;
	logic [LINE_W+1:0] tgt;
	logic [LINE_W+1:0] twice_w;
	logic rst_hit;
	logic [LINE_W-1:0] rst_row;
	logic [GI_DATA_W-1:0] rdata_nxt;
	logic line_strobe;
	logic pulse_fire;

	gi_chan_if ch_if [GI_NCH] ();

	//////////////////////////////////////////////////////////////////////
	// register writes

	// the go bit is a command and is never stored
	assign upd_go = i_reg_wr && (i_reg_addr == GI_A_UPDATE) &&
		i_reg_wdata[GI_UPD_GO_BIT];

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < GI_NPTS; k++) begin
				coef_stage_r[k] <= GI_COEF_RST;
			end
			black_stage_r <= GI_BLACK_RST;
		end else if (i_reg_wr) begin
			// only the low 10 bits of a coefficient write are kept
			if (gi_is_coef(i_reg_addr)) begin
				coef_stage_r[i_reg_addr[2:0]] <= i_reg_wdata[GI_OUT_W-1:0];
			end
			if (i_reg_addr == GI_A_BLACK) begin
				black_stage_r <= i_reg_wdata[GI_OUT_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			chan_sel_r <= 3'h0;
			point_sel_r <= 3'h0;
			dim_r <= GI_DIM_RST;
			maxcur_r <= GI_MAXCUR_RST;
			cath_r <= GI_CATH_RST;
			row_blank_r <= GI_ROWBLANK_RST;
			disp_blank_r <= GI_DISPBLANK_RST;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				GI_A_UPDATE: chan_sel_r <= i_reg_wdata[2:0];
				GI_A_PTSEL: point_sel_r <= i_reg_wdata[2:0];
				GI_A_DIM: dim_r <= i_reg_wdata[GI_DIM_W-1:0];
				GI_A_MAXCUR: maxcur_r <= i_reg_wdata[7:0];
				GI_A_CATHODE: cath_r <= i_reg_wdata[GI_CATH_W-1:0];
				GI_A_ROWBLANK: row_blank_r <= i_reg_wdata[GI_ROWBLANK_W-1:0];
				GI_A_DISPCTL: disp_blank_r <= i_reg_wdata[0];
				default: begin
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// per-channel coefficient banks, loaded on the update command

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int c = 0; c < GI_NCH; c++) begin
				black_r[c] <= GI_BLACK_RST;
				for (int k = 0; k < GI_NPTS; k++) begin
					bank_r[c][k] <= GI_COEF_RST;
				end
			end
		end else if (upd_go) begin
			// channel mask comes from the same write that carries the go bit
			// channels outside the mask keep their curve
			for (int c = 0; c < GI_NCH; c++) begin
				if (i_reg_wdata[c]) begin
					black_r[c] <= black_stage_r;
					for (int k = 0; k < GI_NPTS; k++) begin
						bank_r[c][k] <= coef_stage_r[k];
					end
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// register reads

	always_comb begin
		rdata_nxt = '0;
		// offsets 0..7 read back the staged set, not a channel bank
		if (gi_is_coef(i_reg_addr)) begin
			rdata_nxt[GI_OUT_W-1:0] = coef_stage_r[i_reg_addr[2:0]];
		end else begin
			unique case (i_reg_addr)
				GI_A_BLACK: rdata_nxt[GI_OUT_W-1:0] = black_stage_r;
				GI_A_UPDATE: rdata_nxt[2:0] = chan_sel_r;
				GI_A_PTSEL: rdata_nxt[2:0] = point_sel_r;
				GI_A_DIM: rdata_nxt[GI_DIM_W-1:0] = dim_r;
				GI_A_MAXCUR: rdata_nxt[7:0] = maxcur_r;
				GI_A_CATHODE: rdata_nxt[GI_CATH_W-1:0] = cath_r;
				GI_A_ROWBLANK: rdata_nxt[GI_ROWBLANK_W-1:0] = row_blank_r;
				GI_A_DISPCTL: rdata_nxt[0] = disp_blank_r;
				GI_A_FRAMELEN: rdata_nxt = GI_DATA_W'(frame_len_r);
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= '0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			// read data holds until the next read
			if (i_reg_rd) begin
				o_reg_rdata <= rdata_nxt;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pixel path, one flop stage inside each interpolator

	for (genvar c = 0; c < GI_NCH; c++) begin : g_ch
		assign ch_if[c].blank = disp_blank_r;
		assign ch_if[c].q0 = black_r[c];
		for (genvar k = 0; k < GI_NPTS; k++) begin : g_pt
			assign ch_if[c].coef[k] = bank_r[c][k];
		end
		gi_interp u_interp (
			.i_clk_sys(i_clk_sys),
			.i_rst(i_rst),
			.ch(ch_if[c])
		);
	end

	assign ch_if[0].pix = i_pix_r;
	assign ch_if[1].pix = i_pix_g;
	assign ch_if[2].pix = i_pix_b;
	assign o_pix_r = ch_if[0].res;
	assign o_pix_g = ch_if[1].res;
	assign o_pix_b = ch_if[2].res;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pix_valid_r <= 1'b0;
		end else begin
			// one stage, in step with the interpolator register
			pix_valid_r <= i_pix_valid;
		end
	end

	assign o_pix_valid = pix_valid_r;

	//////////////////////////////////////////////////////////////////////
	// analog control outputs

	assign o_gamma_point_select = point_sel_r;
	// outside cathode modes 0 and 1 the dimming setting is ignored
	assign o_dim_level = (cath_r <= GI_CATH_DIM_MAX) ? dim_r : GI_DIM_FULL;
	assign o_max_current_coarse = maxcur_r[GI_COARSE_LSB +: GI_COARSE_W];
	assign o_max_current_fine = maxcur_r[GI_FINE_W-1:0];
	assign o_cathode_mode = cath_r;
	assign o_display_blank = disp_blank_r;

	//////////////////////////////////////////////////////////////////////
	// line counting and frame length measurement

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			line_r <= '0;
			frame_len_r <= '0;
		end else if (i_vsync) begin
			frame_len_r <= line_r;
			line_r <= '0;
		end else if (i_hsync) begin
			line_r <= line_r + LINE_W'(1);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// row reset: the row whose programming line lies 2*W lines ahead

	always_comb begin
		twice_w = (LINE_W+2)'({row_blank_r, 1'b0});
		tgt_raw = (LINE_W+2)'(line_r) + twice_w;
		// a single subtract wraps, since 2*W stays below the frame length
		if (tgt_raw >= (LINE_W+2)'(frame_len_r))
			tgt = tgt_raw - (LINE_W+2)'(frame_len_r);
		else
			tgt = tgt_raw;
		rst_row = LINE_W'(tgt - (LINE_W+2)'(INIT_LINES));
		// no measured frame length yet after reset keeps the generator quiet
		rst_hit = (row_blank_r != '0) && (frame_len_r != '0) &&
			(twice_w < (LINE_W+2)'(frame_len_r)) &&
			(tgt >= (LINE_W+2)'(INIT_LINES)) &&
			(tgt < (LINE_W+2)'(INIT_LINES + NUM_ROWS));
	end

	// a frame strobe wins over a line strobe in the same cycle
	assign line_strobe = i_hsync && !i_vsync;
	assign pulse_fire = line_strobe && rst_hit;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_row_reset_pulse <= 1'b0;
			o_row_reset_row <= '0;
		end else begin
			o_row_reset_pulse <= pulse_fire;
			if (pulse_fire) begin
				o_row_reset_row <= rst_row;
			end
		end
	end

endmodule : gi_gamma_dim

// >>> verif/gi_vsrc.sv
// video source timing model: one frame strobe, then a fixed count of line strobes
`timescale 1ns/1ps
module gi_vsrc #(
	parameter int LINES = 12,
	parameter int GAP = 3
) (
	input wire logic i_clk_sys,
	input wire logic i_run,
	output logic o_hsync,
	output logic o_vsync
);
	int cyc = 0;
	int ln = LINES;
	initial begin
		o_hsync = 1'b0;
		o_vsync = 1'b0;
	end
	// strobes change only off the sampling edge
	always @(negedge i_clk_sys) begin
		o_hsync <= 1'b0;
		o_vsync <= 1'b0;
		if (i_run) begin
			cyc <= (cyc == GAP) ? 0 : cyc + 1;
			if (cyc == GAP) begin
				ln <= (ln == LINES) ? 0 : ln + 1;
				if (ln == LINES) begin
					o_vsync <= 1'b1;
				end else begin
					o_hsync <= 1'b1;
				end
			end
		end
	end
endmodule : gi_vsrc

// >>> verif/gi_gamma_dim_asserts.sv
// concurrent checks on the gamma and row dimming block ports
`timescale 1ns/1ps
module gi_gamma_dim_asserts (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [4:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic o_reg_rvalid,
	input wire logic i_hsync,
	input wire logic i_vsync,
	input wire logic [9:0] o_pix_r,
	input wire logic [9:0] o_pix_g,
	input wire logic [9:0] o_pix_b,
	input wire logic [2:0] o_gamma_point_select,
	input wire logic [6:0] o_dim_level,
	input wire logic [3:0] o_max_current_coarse,
	input wire logic [3:0] o_max_current_fine,
	input wire logic [3:0] o_cathode_mode,
	input wire logic o_display_blank,
	input wire logic o_row_reset_pulse
);
	import gi_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_rd;
		i_reg_rd |=> o_reg_rvalid;
	endproperty
	property p_rv_cause;
		o_reg_rvalid |-> $past(i_reg_rd);
	endproperty
	property p_ptsel;
		i_reg_wr && i_reg_addr == GI_A_PTSEL |=> o_gamma_point_select == $past(i_reg_wdata[2:0]);
	endproperty
	property p_maxcur;
		i_reg_wr && i_reg_addr == GI_A_MAXCUR |=>
			{o_max_current_coarse, o_max_current_fine} == $past(i_reg_wdata[7:0]);
	endproperty
	property p_dim_wr;
		i_reg_wr && i_reg_addr == GI_A_DIM && o_cathode_mode <= 4'h1 |=>
			o_dim_level == $past(i_reg_wdata[6:0]);
	endproperty
	property p_dim_cath;
		$past(o_cathode_mode) > 4'h1 && o_cathode_mode > 4'h1 |-> o_dim_level == GI_DIM_FULL;
	endproperty
	property p_blank_pix;
		$past(o_display_blank) |-> o_pix_r == 10'h000 && o_pix_g == 10'h000 && o_pix_b == 10'h000;
	endproperty
	property p_pulse_cause;
		o_row_reset_pulse |-> $past(i_hsync) && !$past(i_vsync);
	endproperty
	a_rd: assert property (p_rd) else $error("read answer missing");
	a_rv_cause: assert property (p_rv_cause) else $error("read answer without read");
	a_ptsel: assert property (p_ptsel) else $error("point select wrong");
	a_maxcur: assert property (p_maxcur) else $error("max current fields wrong");
	a_dim_wr: assert property (p_dim_wr) else $error("dim level wrong");
	a_dim_cath: assert property (p_dim_cath) else $error("dim acts in wrong mode");
	a_blank_pix: assert property (p_blank_pix) else $error("pixel shown while blank");
	a_pulse_cause: assert property (p_pulse_cause) else $error("stray row pulse");
	c_pulse: cover property (o_row_reset_pulse);
	c_cath: cover property (o_cathode_mode > 4'h1);
	c_pt7: cover property (o_gamma_point_select == 3'h7);
endmodule : gi_gamma_dim_asserts
bind gi_gamma_dim gi_gamma_dim_asserts u_chk (.*);

// >>> verif/gi_gamma_dim_tb.sv
// self-checking bench for the gamma and row dimming block
`timescale 1ns/1ps
module gi_gamma_dim_tb;
	import gi_pkg::*;
	localparam int LINES = 12;
	localparam int INIT = 2;
	logic i_clk_sys = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_pix_valid = 0, run = 0;
	logic [4:0] i_reg_addr = 0;
	logic [15:0] i_reg_wdata = 0, o_reg_rdata, o_row_reset_row;
	logic [7:0] i_pix_r = 0, i_pix_g = 0, i_pix_b = 0;
	logic o_reg_rvalid, o_pix_valid, i_hsync, i_vsync, o_display_blank, o_row_reset_pulse;
	logic [9:0] o_pix_r, o_pix_g, o_pix_b;
	logic [2:0] o_gamma_point_select;
	logic [6:0] o_dim_level;
	logic [3:0] o_max_current_coarse, o_max_current_fine, o_cathode_mode;
	int err_total = 0, tests_run = 0;
	// host sense readings in mV against a 2500 mV full scale, factors per mille
	int sense_mv[8] = '{400, 430, 470, 520, 600, 700, 850, 1200};
	int corr_pm[8] = '{870, 880, 900, 922, 940, 955, 968, 1000};
	int c1[8];
	gi_gamma_dim #(.INIT_LINES(INIT)) uut (.*);
	gi_vsrc #(.LINES(LINES)) u_src (.i_clk_sys(i_clk_sys), .i_run(run), .o_hsync(i_hsync),
		.o_vsync(i_vsync));
	initial forever #12.5 i_clk_sys = ~i_clk_sys;
	//////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(logic [4:0] a, logic [15:0] d);
		@(negedge i_clk_sys);
		i_reg_wr = 1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_clk_sys);
		i_reg_wr = 0;
	endtask : wr
	task automatic rd(logic [4:0] a, logic [15:0] e, string n);
		@(negedge i_clk_sys);
		i_reg_rd = 1;
		i_reg_addr = a;
		@(negedge i_clk_sys);
		i_reg_rd = 0;
		chk("read valid", o_reg_rvalid, 16'h0001);
		chk(n, o_reg_rdata, e);
	endtask : rd
	task automatic pix(logic [7:0] x);
		@(negedge i_clk_sys);
		i_pix_r = x;
		i_pix_g = x;
		i_pix_b = x;
		i_pix_valid = 1;
		@(negedge i_clk_sys);
	endtask : pix
	task automatic wait_vs();
		int n = 0;
		@(negedge i_clk_sys);
		while (!i_vsync) begin
			n++;
			if (n > 500) begin
				err_total++;
				print_verdict();
			end
			@(negedge i_clk_sys);
		end
	endtask : wait_vs
	// reference curve: black level at zero, else bracketing segment
	function automatic int gam(int x, int c[8], int q);
		int k, lo, hi, y;
		if (x == 0) return q;
		k = 0;
		for (int i = 0; i < 7; i++) if (GI_GL[i] <= x) k = i;
		lo = GI_GL[k];
		hi = GI_GL[k + 1];
		y = c[k] + (x - lo) * (c[k + 1] - c[k]) / (hi - lo);
		return (y < 0) ? 0 : (y > 1023) ? 1023 : y;
	endfunction : gam
	//////////////////////////////////////////////////
	task automatic t_reset();
		chk("blank out", o_display_blank, 16'h0001);
		chk("dim out", o_dim_level, 16'h007f);
		chk("valid idle", o_pix_valid, 16'h0000);
		rd(GI_A_DIM, 16'h007f, "dim reg");
		rd(GI_A_BLACK, 16'h0001, "black reg");
		rd(GI_A_ROWBLANK, 16'h0000, "row blank reg");
		rd(GI_A_DISPCTL, 16'h0001, "disp reg");
		rd(5'h1f, 16'h0000, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_gamma();
		logic [7:0] xs[9] = '{0, 1, 3, 4, 6, 100, 200, 254, 255};
		int c2[8];
		pix(8'hff);
		chk("blank pix", o_pix_g, 16'h0000);
		for (int i = 0; i < 8; i++) wr(GI_A_COEF0 + 5'(i), 16'(c1[i]));
		wr(GI_A_BLACK, 16'h0003);
		wr(GI_A_UPDATE, 16'h0009);
		for (int i = 0; i < 8; i++) begin
			c2[i] = c1[i] / 2;
			wr(GI_A_COEF0 + 5'(i), 16'(c2[i]));
		end
		wr(GI_A_BLACK, 16'h0005);
		wr(GI_A_UPDATE, 16'h000e);
		rd(GI_A_UPDATE, 16'h0006, "update mask");
		wr(GI_A_DISPCTL, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			pix(xs[i]);
			chk("pix valid", o_pix_valid, 16'h0001);
			chk("pix r", o_pix_r, 16'(gam(xs[i], c1, 3)));
			chk("pix g", o_pix_g, 16'(gam(xs[i], c2, 5)));
			chk("pix b", o_pix_b, 16'(gam(xs[i], c2, 5)));
		end
		$display("test gamma done");
	endtask : t_gamma
	task automatic t_ctl();
		int dv;
		// host sensing pass: settle one full frame, sample at the frame strobe
		for (int i = 0; i < 8; i++) begin
			wr(GI_A_PTSEL, 16'(i));
			chk("point select", o_gamma_point_select, 16'(i));
			wait_vs();
			wait_vs();
			dv = sense_mv[i] * 1023 / 2500;
			c1[i] = dv * corr_pm[i] / 1000;
		end
		wr(GI_A_MAXCUR, 16'h00a5);
		chk("coarse", o_max_current_coarse, 16'h000a);
		chk("fine", o_max_current_fine, 16'h0005);
		wr(GI_A_DIM, 16'h0040);
		for (int i = 0; i < 4; i++) begin
			wr(GI_A_CATHODE, 16'(i));
			chk("cathode", o_cathode_mode, 16'(i));
			chk("dim mode", o_dim_level, (i < 2) ? 16'h0040 : 16'h007f);
		end
		wr(GI_A_COEF0, 16'hffff);
		rd(GI_A_COEF0, 16'h03ff, "coef width");
		$display("test controls done");
	endtask : t_ctl
	task automatic t_row(int w);
		int n = 0, s = 0, f = -1;
		int ne = (w != 0 && 2 * w < LINES) ? LINES - INIT : 0;
		bit hit = 0;
		rd(GI_A_FRAMELEN, 16'(LINES), "frame length");
		wr(GI_A_ROWBLANK, 16'(w));
		wait_vs();
		repeat (LINES * 4 + 8) begin
			@(negedge i_clk_sys);
			if (i_vsync) begin
				hit = 1;
				break;
			end
			if (o_row_reset_pulse) begin
				n++;
				s += o_row_reset_row;
				if (f < 0) f = o_row_reset_row;
			end
		end
		if (!hit) begin
			err_total++;
			print_verdict();
		end
		chk("pulse count", 16'(n), 16'(ne));
		chk("row sum", 16'(s), 16'(ne * (ne - 1) / 2));
		chk("first row", 16'(f), (ne > 0) ? 16'(2 * w - INIT) : 16'hffff);
		$display("test row blank %0d done", w);
	endtask : t_row
	//////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge i_clk_sys);
		i_rst = 0;
		t_reset();
		run = 1;
		t_ctl();
		t_gamma();
		t_row(0);
		t_row(1);
		t_row(2);
		t_row(5);
		t_row(6);
		print_verdict();
	end
endmodule : gi_gamma_dim_tb
